// *** hdl/slb_pkg.sv ***
package slb_pkg;

   // Shared-memory handshake words
   localparam logic [31:0] SLB_MAILBOX_ADDR = 32'hC0101C00;
   localparam logic [31:0] SLB_ENTRY_ADDR = 32'hC0101C10;
   localparam logic [31:0] SLB_WAIT_MARKER = 32'h17171717;
   localparam logic [31:0] SLB_RELEASE_CODE = 32'hA5A5A5A5;

   // Protocol select fields inside the low reset configuration word
   localparam int SLB_P1_LSB = 0;
   localparam int SLB_P2_LSB = 4;
   localparam int SLB_PSEL_W = 4;
   localparam logic [3:0] SLB_PSEL_OFF = 4'h0;
   localparam logic [3:0] SLB_PSEL_4X = 4'h4;

   // Register byte offsets
   localparam logic [7:0] SLB_REG_CTRL = 8'h00;
   localparam logic [7:0] SLB_REG_POLL = 8'h04;
   localparam logic [7:0] SLB_REG_STATUS = 8'h08;
   localparam logic [7:0] SLB_REG_CFG_LO = 8'h0C;
   localparam logic [7:0] SLB_REG_CFG_HI = 8'h10;
   localparam logic [7:0] SLB_REG_ENTRY = 8'h14;
   localparam logic [7:0] SLB_REG_MBOX = 8'h18;

   localparam int SLB_CTRL_HOLD_BIT = 0;
   localparam logic SLB_CTRL_HOLD_RST = 1'b0;
   localparam logic [15:0] SLB_POLL_GAP_RST = 16'h0040;

   localparam logic [1:0] SLB_RESP_OKAY = 2'h0;
   localparam logic [1:0] SLB_RESP_SLVERR = 2'h2;

   typedef enum logic [3:0] {
      SLB_FETCH_LO,
      SLB_WAIT_LO,
      SLB_FETCH_HI,
      SLB_WAIT_HI,
      SLB_LANES,
      SLB_MARK,
      SLB_POLL_GAP,
      SLB_POLL,
      SLB_ENTRY,
      SLB_RUN
   } slb_state_t;

   typedef struct packed {
      logic valid;
      logic we;
      logic [31:0] addr;
      logic [31:0] wdata;
   } slb_mem_req_t;

   typedef struct packed {
      logic req;
      logic sel_high;
   } slb_cfg_req_t;

endpackage : slb_pkg

// *** hdl/slb_boot_handshake.sv ***
// Overview of operation
// - After the config words, enable serial link and lanes if port one selects four-lane mode and hold is clear, then write wait marker to mailbox.
// - After the marker, keep reading the mailbox until the release code appears.
// - On release, load program counter from entry word and start running there.
// - Out of reset, fetch low and high reset configuration words from EEPROM.
//
// Implementation choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/10ps
module slb_boot_handshake
   import slb_pkg::*;
(
   input wire logic core_clk, // System clock
   input wire logic rst_n, // Asynchronous reset, active low
   output slb_cfg_req_t cfg_req, // Config word fetch request
   input wire logic cfg_valid, // Config word returned
   input wire logic [31:0] cfg_data, // Config word value
   output logic link_enable, // Serial port one and lanes enabled
   input wire logic link_up, // Link trained, from link pins
   output slb_mem_req_t mem_req, // Shared memory access
   input wire logic mem_ack, // Shared memory access done
   input wire logic [31:0] mem_rdata, // Shared memory read data
   output logic pc_load, // Program counter load pulse
   output logic [31:0] pc_value, // Program counter target
   input wire logic [7:0] s_axi_awaddr, // AXI write address
   input wire logic s_axi_awvalid, // AXI write address valid
   output logic s_axi_awready, // AXI write address ready
   input wire logic [31:0] s_axi_wdata, // AXI write data
   input wire logic [3:0] s_axi_wstrb, // AXI write strobes
   input wire logic s_axi_wvalid, // AXI write data valid
   output logic s_axi_wready, // AXI write data ready
   output logic [1:0] s_axi_bresp, // AXI write response
   output logic s_axi_bvalid, // AXI write response valid
   input wire logic s_axi_bready, // AXI write response ready
   input wire logic [7:0] s_axi_araddr, // AXI read address
   input wire logic s_axi_arvalid, // AXI read address valid
   output logic s_axi_arready, // AXI read address ready
   output logic [31:0] s_axi_rdata, // AXI read data
   output logic [1:0] s_axi_rresp, // AXI read response
   output logic s_axi_rvalid, // AXI read data valid
   input wire logic s_axi_rready // AXI read data ready
);

   typedef struct packed {
      slb_state_t st;
      logic [31:0] cfg_lo;
      logic [31:0] cfg_hi;
      logic [31:0] entry;
      logic [31:0] mbox;
      logic hold;
      logic [15:0] gap;
      logic [15:0] cnt;
      slb_cfg_req_t cfg;
      slb_mem_req_t mem;
      logic link_en;
      logic conflict;
      logic pc_load;
      logic [31:0] pc;
      logic up_meta;
      logic up_sync;
      logic aw_got;
      logic w_got;
      logic [7:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } slb_regs_t;

   localparam slb_regs_t SLB_REGS_RST = '{
      st: SLB_FETCH_LO,
      hold: SLB_CTRL_HOLD_RST,
      gap: SLB_POLL_GAP_RST,
      default: '0
   };

   slb_regs_t r;
   slb_regs_t next_r;

   function automatic logic [31:0] slb_merge(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0] be);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            res[8*i +: 8] = wd[8*i +: 8];
         end
      end
      return res;
   endfunction : slb_merge

   function automatic logic [3:0] slb_psel(input logic [31:0] w,
                                           input int lsb);
      return w[lsb +: SLB_PSEL_W];
   endfunction : slb_psel

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      logic [31:0] wv;
      logic [31:0] rv;
      logic rok;
      wv = '0;
      rv = '0;
      rok = 1'b1;
      next_r = r;
      next_r.pc_load = 1'b0;
      // Link status pin synchroniser
      next_r.up_meta = link_up;
      next_r.up_sync = r.up_meta;

      case (r.st)
         SLB_FETCH_LO: begin
            next_r.cfg = '{req: 1'b1, sel_high: 1'b0};
            next_r.st = SLB_WAIT_LO;
         end
         SLB_WAIT_LO: begin
            if (cfg_valid) begin
               next_r.cfg_lo = cfg_data;
               next_r.cfg.req = 1'b0;
               next_r.st = SLB_FETCH_HI;
            end
         end
         SLB_FETCH_HI: begin
            next_r.cfg = '{req: 1'b1, sel_high: 1'b1};
            next_r.st = SLB_WAIT_HI;
         end
         SLB_WAIT_HI: begin
            if (cfg_valid) begin
               next_r.cfg_hi = cfg_data;
               next_r.cfg.req = 1'b0;
               // Both ports active would duplicate the device identifier
               next_r.conflict =
                  (slb_psel(r.cfg_lo, SLB_P1_LSB) != SLB_PSEL_OFF) &&
                  (slb_psel(r.cfg_lo, SLB_P2_LSB) != SLB_PSEL_OFF);
               next_r.st = SLB_LANES;
            end
         end
         SLB_LANES: begin
            // Only port one is ever opened, in four-lane mode
            if (!r.hold &&
                slb_psel(r.cfg_lo, SLB_P1_LSB) == SLB_PSEL_4X) begin
               next_r.link_en = 1'b1;
            end
            if (r.link_en && r.up_sync) begin
               next_r.mem = '{valid: 1'b1, we: 1'b1, addr: SLB_MAILBOX_ADDR,
                              wdata: SLB_WAIT_MARKER};
               next_r.st = SLB_MARK;
            end
         end
         SLB_MARK: begin
            if (mem_ack) begin
               next_r.mem.valid = 1'b0;
               next_r.cnt = '0;
               next_r.st = SLB_POLL_GAP;
            end
         end
         SLB_POLL_GAP: begin
            next_r.cnt = r.cnt + 16'h0001;
            if (r.cnt >= r.gap) begin
               next_r.mem = '{valid: 1'b1, we: 1'b0, addr: SLB_MAILBOX_ADDR,
                              wdata: '0};
               next_r.st = SLB_POLL;
            end
         end
         SLB_POLL: begin
            if (mem_ack) begin
               next_r.mem.valid = 1'b0;
               next_r.mbox = mem_rdata;
               next_r.cnt = '0;
               if (mem_rdata == SLB_RELEASE_CODE) begin
                  next_r.mem = '{valid: 1'b1, we: 1'b0, addr: SLB_ENTRY_ADDR,
                                 wdata: '0};
                  next_r.st = SLB_ENTRY;
               end else begin
                  next_r.st = SLB_POLL_GAP;
               end
            end
         end
         SLB_ENTRY: begin
            if (mem_ack) begin
               next_r.mem.valid = 1'b0;
               next_r.entry = mem_rdata;
               next_r.pc = mem_rdata;
               next_r.pc_load = 1'b1;
               next_r.st = SLB_RUN;
            end
         end
         SLB_RUN: begin
            next_r.st = SLB_RUN;
         end
         default: begin
            next_r.st = SLB_FETCH_LO;
         end
      endcase

      ////////////////////////////////////////////////////////////////////
      // AXI4-Lite write path
      if (s_axi_awvalid && !r.aw_got && !r.bvalid) begin
         next_r.aw_got = 1'b1;
         next_r.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !r.w_got && !r.bvalid) begin
         next_r.w_got = 1'b1;
         next_r.wdata = s_axi_wdata;
         next_r.wstrb = s_axi_wstrb;
      end
      if (r.aw_got && r.w_got && !r.bvalid) begin
         next_r.aw_got = 1'b0;
         next_r.w_got = 1'b0;
         next_r.bvalid = 1'b1;
         next_r.bresp = SLB_RESP_OKAY;
         case (r.awaddr)
            SLB_REG_CTRL: begin
               wv = slb_merge({31'h0, r.hold}, r.wdata, r.wstrb);
               next_r.hold = wv[SLB_CTRL_HOLD_BIT];
            end
            SLB_REG_POLL: begin
               wv = slb_merge({16'h0, r.gap}, r.wdata, r.wstrb);
               next_r.gap = wv[15:0];
            end
            SLB_REG_STATUS, SLB_REG_CFG_LO, SLB_REG_CFG_HI,
            SLB_REG_ENTRY, SLB_REG_MBOX: begin
               next_r.bresp = SLB_RESP_OKAY;
            end
            default: begin
               next_r.bresp = SLB_RESP_SLVERR;
            end
         endcase
      end
      if (r.bvalid && s_axi_bready) begin
         next_r.bvalid = 1'b0;
      end

      // AXI4-Lite read path
      if (s_axi_arvalid && !r.rvalid) begin
         case (s_axi_araddr)
            SLB_REG_CTRL: rv = {31'h0, r.hold};
            SLB_REG_POLL: rv = {16'h0, r.gap};
            SLB_REG_STATUS: rv = {23'h0, r.st, 1'b0, r.conflict,
                                  r.up_sync, r.link_en,
                                  r.st == SLB_RUN};
            SLB_REG_CFG_LO: rv = r.cfg_lo;
            SLB_REG_CFG_HI: rv = r.cfg_hi;
            SLB_REG_ENTRY: rv = r.entry;
            SLB_REG_MBOX: rv = r.mbox;
            default: rok = 1'b0;
         endcase
         next_r.rvalid = 1'b1;
         next_r.rdata = rv;
         next_r.rresp = rok ? SLB_RESP_OKAY : SLB_RESP_SLVERR;
      end else if (r.rvalid && s_axi_rready) begin
         next_r.rvalid = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         r <= SLB_REGS_RST;
      end else begin
         r <= next_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   assign cfg_req = r.cfg;
   assign link_enable = r.link_en;
   assign mem_req = r.mem;
   assign pc_load = r.pc_load;
   assign pc_value = r.pc;
   assign s_axi_awready = !r.aw_got && !r.bvalid;
   assign s_axi_wready = !r.w_got && !r.bvalid;
   assign s_axi_bvalid = r.bvalid;
   assign s_axi_bresp = r.bresp;
   assign s_axi_arready = !r.rvalid;
   assign s_axi_rvalid = r.rvalid;
   assign s_axi_rdata = r.rdata;
   assign s_axi_rresp = r.rresp;

endmodule : slb_boot_handshake

// *** dv/slb_boot_handshake_assertions.sv ***
`timescale 1ns/10ps
module slb_boot_handshake_assertions
   import slb_pkg::*;
(
   input wire logic core_clk, // Clock
   input wire logic rst_n, // Reset, active low
   input slb_cfg_req_t cfg_req, // Config request
   input wire logic cfg_valid, // Config answer
   input wire logic [31:0] cfg_data, // Config word
   input wire logic link_enable, // Port one opened
   input slb_mem_req_t mem_req, // Memory access
   input wire logic mem_ack, // Memory done
   input wire logic [31:0] mem_rdata, // Read data
   input wire logic pc_load, // Jump pulse
   input wire logic [31:0] pc_value, // Jump target
   input wire logic s_axi_arvalid, // Read address valid
   input wire logic s_axi_arready, // Read address ready
   input wire logic s_axi_rvalid // Read data valid
);
   logic [1:0] ncfg;
   logic [3:0] p1;
   logic marked;
   logic rel;
   logic mbx;
   logic ent;
   assign mbx = mem_req.valid && !mem_req.we &&
      mem_req.addr == SLB_MAILBOX_ADDR;
   assign ent = mem_req.valid && !mem_req.we &&
      mem_req.addr == SLB_ENTRY_ADDR;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ncfg <= '0;
         p1 <= '0;
         marked <= 1'b0;
         rel <= 1'b0;
      end else begin
         if (cfg_req.req && cfg_valid) begin
            ncfg <= ncfg + 2'd1;
            if (ncfg == 2'd0) p1 <= cfg_data[3:0];
         end
         if (mem_req.valid && mem_ack && mem_req.we) marked <= 1'b1;
         if (mbx && mem_ack && mem_rdata == SLB_RELEASE_CODE) rel <= 1'b1;
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   a_cfg_order: assert property (cfg_req.req |->
      ncfg < 2'd2 && cfg_req.sel_high == (ncfg == 2'd1))
      else $error("config words out of order");
   a_link_cfg: assert property (link_enable |->
      ncfg == 2'd2 && p1 == SLB_PSEL_4X) else $error("link opened early");
   a_mark_first: assert property (mem_req.valid && !marked |->
      link_enable && mem_req.we && mem_req.addr == SLB_MAILBOX_ADDR &&
      mem_req.wdata == SLB_WAIT_MARKER) else $error("bad marker write");
   a_poll_only: assert property (mem_req.valid && marked && !rel |->
      mbx) else $error("not polling mailbox");
   a_entry_late: assert property (ent |-> rel)
      else $error("entry read before release");
   a_keep_wait: assert property (mbx && mem_ack &&
      mem_rdata != SLB_RELEASE_CODE |=> !mem_req.valid && !pc_load)
      else $error("left wait without release");
   a_release_go: assert property (mbx && mem_ack &&
      mem_rdata == SLB_RELEASE_CODE |=> ent) else $error("no entry read");
   a_pc_load: assert property (ent && mem_ack |=>
      pc_load && pc_value == $past(mem_rdata)) else $error("bad jump");
   a_pc_once: assert property (pc_load |=>
      (!pc_load && $stable(pc_value)) [*8]) else $error("jump repeated");
   a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=>
      s_axi_rvalid) else $error("read not answered");
endmodule : slb_boot_handshake_assertions
bind slb_boot_handshake slb_boot_handshake_assertions i_chk (.core_clk,
   .rst_n, .cfg_req, .cfg_valid, .cfg_data, .link_enable, .mem_req,
   .mem_ack, .mem_rdata, .pc_load, .pc_value, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rvalid);

// *** dv/slb_boot_host.sv ***
`timescale 1ns/10ps
module slb_boot_host
   import slb_pkg::*;
(
   input wire logic core_clk, // Clock
   input wire logic rst_n, // Reset, active low
   input slb_cfg_req_t cfg_req, // Config request
   output logic cfg_valid, // Config answer
   output logic [31:0] cfg_data, // Config word
   input wire logic link_enable, // Port one opened
   output logic link_up, // Link trained
   input slb_mem_req_t mem_req, // Memory access
   output logic mem_ack, // Memory done
   output logic [31:0] mem_rdata, // Read data
   input wire logic [31:0] cfg_lo, // Low config word
   input wire logic [31:0] cfg_hi, // High config word
   input wire logic [31:0] entry, // Start address to load
   input wire logic [7:0] rel_at, // Polls before release
   input wire logic slow // Stretch answers
);
   logic [31:0] mbox;
   logic [31:0] ent;
   logic [7:0] polls;
   logic [1:0] dly;
   logic go;
   assign go = dly == 2'd0 && !cfg_valid && !mem_ack;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         {cfg_valid, mem_ack, link_up, dly, polls} <= '0;
         {cfg_data, mem_rdata, mbox, ent} <= '0;
      end else begin
         // Link trains and the host enumerates right after enable
         link_up <= link_enable;
         cfg_valid <= cfg_req.req && go;
         mem_ack <= mem_req.valid && go;
         // Idle data lines toggle so stale values never look valid
         cfg_data <= ~cfg_data;
         mem_rdata <= ~mem_rdata;
         if (dly != 2'd0) dly <= dly - 2'd1;
         else if (go && (cfg_req.req || mem_req.valid)) dly <= {slow, slow};
         if (cfg_req.req && go) cfg_data <= cfg_req.sel_high ? cfg_hi : cfg_lo;
         if (mem_req.valid && go && mem_req.we &&
            mem_req.addr == SLB_MAILBOX_ADDR) mbox <= mem_req.wdata;
         if (mem_req.valid && go && !mem_req.we) begin
            mem_rdata <= mem_req.addr == SLB_ENTRY_ADDR ? ent : mbox;
            polls <= polls + 8'd1;
            // A near-miss value first, then entry, then release last
            if (polls == 8'd0) mbox <= SLB_RELEASE_CODE ^ 32'h1;
            if (polls == rel_at - 8'd1) ent <= entry;
            if (polls == rel_at) mbox <= SLB_RELEASE_CODE;
         end
      end
   end
endmodule : slb_boot_host

// *** dv/test_serial_link_boot_handshake.sv ***
`timescale 1ns/10ps
module test_serial_link_boot_handshake
   import slb_pkg::*;
;
   logic core_clk, rst_n, cfg_valid, link_enable, link_up, mem_ack;
   logic pc_load, slow, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
   logic s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   logic [7:0] s_axi_awaddr, s_axi_araddr, rel_at;
   logic [31:0] cfg_data, mem_rdata, pc_value, cfg_lo, cfg_hi, entry;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd, dw;
   logic [3:0] s_axi_wstrb;
   slb_cfg_req_t cfg_req;
   slb_mem_req_t mem_req;
   int error_cnt = 0;
   int n_tests = 0;
   int n;
   slb_boot_handshake i_dut (.core_clk, .rst_n, .cfg_req, .cfg_valid,
      .cfg_data, .link_enable, .link_up, .mem_req, .mem_ack, .mem_rdata,
      .pc_load, .pc_value, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready);
   slb_boot_host i_host (.core_clk, .rst_n, .cfg_req, .cfg_valid,
      .cfg_data, .link_enable, .link_up, .mem_req, .mem_ack, .mem_rdata,
      .cfg_lo, .cfg_hi, .entry, .rel_at, .slow);
   ////////////////////////////////////////////////////////////////////
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : wrap_up
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic hang;
      error_cnt++;
      $display("MISMATCH %0t wait ran out", $time);
      wrap_up();
   endtask : hang
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      n = 0;
      do begin
         @(posedge core_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         n++;
      end while (!s_axi_bvalid && n < 200);
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
      if (n >= 200) hang();
      @(posedge core_clk);
   endtask : axi_wr
   task automatic axi_rd(input logic [7:0] a);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      n = 0;
      do begin
         @(posedge core_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         n++;
      end while (!s_axi_rvalid && n < 200);
      rd = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
      if (n >= 200) hang();
      @(posedge core_clk);
   endtask : axi_rd
   ////////////////////////////////////////////////////////////////////
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   initial begin
      {rst_n, slow, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
      {s_axi_wdata, cfg_lo, cfg_hi, entry} = '0;
      s_axi_wstrb = 4'hF;
      rel_at = 8'h2;
      void'($urandom(70424));
      for (int t = 0; t < 4; t++) begin
         dw = $urandom();
         dw[7:0] = t == 1 ? 8'h44 : t == 2 ? 8'h40 : 8'h04;
         cfg_lo <= dw;
         cfg_hi <= $urandom();
         entry <= $urandom();
         rel_at <= 8'h2 + 8'($urandom_range(4));
         slow <= t[0];
         rst_n <= 1'b0;
         repeat (8) @(posedge core_clk);
         rst_n <= 1'b1;
         if (t == 0) begin
            axi_rd(SLB_REG_POLL);
            chk(rd, {16'h0, SLB_POLL_GAP_RST});
            axi_rd(8'h1C);
            chk({rd[29:0], resp}, {30'h0, SLB_RESP_SLVERR});
            axi_wr(8'h1C, 32'h0);
            chk({30'h0, resp}, {30'h0, SLB_RESP_SLVERR});
            axi_wr(SLB_REG_MBOX, 32'h0);
            chk({30'h0, resp}, {30'h0, SLB_RESP_OKAY});
            // Only byte lane one of the poll gap may change
            s_axi_wstrb <= 4'h2;
            axi_wr(SLB_REG_POLL, 32'h00001200);
            s_axi_wstrb <= 4'hF;
            axi_rd(SLB_REG_POLL);
            chk(rd, {16'h0, 8'h12, SLB_POLL_GAP_RST[7:0]});
         end
         axi_wr(SLB_REG_CTRL, {31'h0, t == 3});
         axi_wr(SLB_REG_POLL, 32'($urandom_range(3, 1)));
         axi_rd(SLB_REG_CTRL);
         chk(rd, {31'h0, t == 3});
         if (t < 2) begin
            for (n = 0; n < 3000 && pc_load !== 1'b1; n++) @(posedge core_clk);
            if (n >= 3000) hang();
            chk(pc_value, entry);
            axi_rd(SLB_REG_STATUS);
            chk(rd & 32'hF, t == 1 ? 32'hF : 32'h7);
            axi_rd(SLB_REG_CFG_LO);
            chk(rd, cfg_lo);
            axi_rd(SLB_REG_CFG_HI);
            chk(rd, cfg_hi);
            axi_rd(SLB_REG_ENTRY);
            chk(rd, entry);
            axi_rd(SLB_REG_MBOX);
            chk(rd, SLB_RELEASE_CODE);
         end else begin
            repeat (80) @(posedge core_clk);
            chk({31'h0, link_enable}, 32'h0);
            chk({31'h0, mem_req.valid}, 32'h0);
         end
         $display("test %0d done", t);
      end
      wrap_up();
   end
endmodule : test_serial_link_boot_handshake
